// ### core/pcc_punctured_conv_codec.sv
// Punctured convolutional encoder and soft-decision Viterbi decoder.
`timescale 1ns/1ns

module pcc_punctured_conv_codec
	import pcc_pkg::*;
#(
	parameter logic [6:0] GEN_FIRST  = GEN_FIRST_DEF,
	parameter logic [6:0] GEN_SECOND = GEN_SECOND_DEF,
	parameter int         TRUNC      = TRUNC_LEN
) (
	// Clock and reset.
	input  wire logic                     i_clk_sys,
	input  wire logic                     i_nrst,
	// Rate selection shared by both directions.
	input  wire pcc_rate_type             i_rate,
	// Encoder data source side.
	input  wire logic                     i_enc_valid,
	input  wire logic                     i_enc_bit,
	input  wire logic                     i_enc_start,
	output logic                          o_enc_ready,
	// Encoder modulator side.
	output logic                          o_enc_sym_valid,
	output logic                          o_enc_sym,
	// Decoder demodulator side.
	input  wire logic                     i_dec_valid,
	input  wire logic signed [SOFT_W-1:0] i_dec_sym,
	input  wire logic                     i_dec_start,
	// Decoder frame consumer side.
	output logic                          o_dec_valid,
	output logic                          o_dec_bit
);

	localparam int FILL_W = $clog2(TRUNC + 1);
	localparam logic [FILL_W-1:0] FILL_FULL = FILL_W'(TRUNC);
	localparam logic signed [SOFT_W+1:0] SOFT_BIAS =
		(SOFT_W+2)'(1 << (SOFT_W - 1));

	logic                     rst_meta;
	logic                     rst_n;

	logic [MEM_LEN-1:0]       enc_sr;
	logic [PHASE_W-1:0]       enc_phase;
	logic                     pend_keep1;
	logic                     pend_keep2;
	logic                     pend_sym1;
	logic                     pend_sym2;
	logic                     enc_take;
	logic [MEM_LEN:0]         enc_window;
	logic [PHASE_W-1:0]       enc_phase_now;
	pcc_keep_type             enc_keep;
	logic                     next_keep1;
	logic                     next_keep2;

	logic [PHASE_W-1:0]       dp_phase;
	logic                     dp_have1;
	logic signed [SOFT_W-1:0] dp_y1;
	pcc_soft_pair_type        pair;
	logic                     pair_valid;
	logic [PHASE_W-1:0]       dp_phase_now;
	logic                     dp_have_now;
	pcc_keep_type             dp_keep;

	logic [PMETRIC_W-1:0]     pm      [NUM_STATES];
	logic [PMETRIC_W-1:0]     next_pm [NUM_STATES];
	logic [TRUNC-1:0]         surv    [NUM_STATES];
	logic [TRUNC-1:0]         next_surv [NUM_STATES];
	logic [MEM_LEN-1:0]       best_state;
	logic [FILL_W-1:0]        fill;

	// Modular compare keeps metrics bounded without a renormalising pass.
	function automatic logic metric_less(logic [PMETRIC_W-1:0] a,
			logic [PMETRIC_W-1:0] b);
		logic [PMETRIC_W-1:0] diff;
		diff = a - b;
		metric_less = diff[PMETRIC_W-1];
	endfunction : metric_less

	function automatic logic signed [SOFT_W-1:0] neg_sat(
			logic signed [SOFT_W-1:0] y);
		if (y == {1'b1, {(SOFT_W-1){1'b0}}})
			neg_sat = {1'b0, {(SOFT_W-1){1'b1}}};
		else
			neg_sat = -y;
	endfunction : neg_sat

	// Cost of one soft symbol against an expected code bit.
	function automatic logic [SOFT_W:0] sym_cost(logic c,
			logic signed [SOFT_W-1:0] y);
		logic signed [SOFT_W+1:0] ye;
		ye = (SOFT_W+2)'(y);
		if (c)
			sym_cost = (SOFT_W+1)'(SOFT_BIAS - ye);
		else
			sym_cost = (SOFT_W+1)'(SOFT_BIAS + ye);
	endfunction : sym_cost

	function automatic logic [PMETRIC_W-1:0] branch_metric(
			logic [MEM_LEN:0] window, pcc_soft_pair_type p);
		logic c1;
		logic c2;
		c1 = ^(window & GEN_FIRST);
		c2 = ^(window & GEN_SECOND);
		branch_metric = PMETRIC_W'(sym_cost(c1, p.first_parity_symbol))
			+ PMETRIC_W'(sym_cost(c2, p.second_parity_symbol));
	endfunction : branch_metric

	// Reset falls at once but rises only on a clock edge, two flops later.
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// Encoder front: a bit is taken only when at most one symbol is pending.
	always_comb begin
		enc_take      = i_enc_valid & o_enc_ready;
		enc_phase_now = i_enc_start ? '0 : enc_phase;
		enc_window    = {i_enc_bit,
			(i_enc_start ? {MEM_LEN{1'b0}} : enc_sr)};
		enc_keep      = keep_bits(i_rate, enc_phase_now);
		if (enc_take) begin
			next_keep1 = enc_keep.keep_first;
			next_keep2 = enc_keep.keep_second;
		end else if (pend_keep1) begin
			next_keep1 = 1'b0;
			next_keep2 = pend_keep2;
		end else begin
			next_keep1 = 1'b0;
			next_keep2 = 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			enc_sr    <= '0;
			enc_phase <= '0;
		end else if (enc_take) begin
			enc_sr    <= enc_window[MEM_LEN:1];
			enc_phase <= next_phase(i_rate, enc_phase_now);
		end else if (i_enc_start) begin
			enc_sr    <= '0;
			enc_phase <= '0;
		end
	end

	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pend_keep1  <= 1'b0;
			pend_keep2  <= 1'b0;
			pend_sym1   <= 1'b0;
			pend_sym2   <= 1'b0;
			o_enc_ready <= 1'b0;
		end else begin
			pend_keep1  <= next_keep1;
			pend_keep2  <= next_keep2;
			o_enc_ready <= ~(next_keep1 & next_keep2);
			if (enc_take) begin
				pend_sym1 <= ^(enc_window & GEN_FIRST);
				pend_sym2 <= ~(^(enc_window & GEN_SECOND));
			end
		end
	end

	// The modulator cannot stall; one symbol leaves per cycle at most.
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			o_enc_sym_valid <= 1'b0;
			o_enc_sym       <= 1'b0;
		end else begin
			o_enc_sym_valid <= pend_keep1 | pend_keep2;
			o_enc_sym       <= pend_keep1 ? pend_sym1 : pend_sym2;
		end
	end

	// Depuncturer: rebuilds a full symbol pair per bit time.
	always_comb begin
		dp_phase_now = i_dec_start ? '0 : dp_phase;
		dp_have_now  = i_dec_start ? 1'b0 : dp_have1;
		dp_keep      = keep_bits(i_rate, dp_phase_now);
	end

	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			dp_phase   <= '0;
			dp_have1   <= 1'b0;
			dp_y1      <= '0;
			pair       <= '0;
			pair_valid <= 1'b0;
		end else begin
			pair_valid <= 1'b0;
			if (i_dec_valid) begin
				// A bit time keeping both symbols parks the first one here.
				if (!dp_have_now && dp_keep.keep_first
						&& dp_keep.keep_second) begin
					dp_y1    <= i_dec_sym;
					dp_have1 <= 1'b1;
					dp_phase <= dp_phase_now;
				end else begin
					pair_valid <= 1'b1;
					dp_have1   <= 1'b0;
					dp_phase   <= next_phase(i_rate, dp_phase_now);
					if (dp_have_now)
						pair.first_parity_symbol <= dp_y1;
					else if (dp_keep.keep_first)
						pair.first_parity_symbol <= i_dec_sym;
					else
						pair.first_parity_symbol <= '0;
					if (dp_keep.keep_second)
						pair.second_parity_symbol <= neg_sat(i_dec_sym);
					else
						pair.second_parity_symbol <= '0;
				end
			end else if (i_dec_start) begin
				dp_have1 <= 1'b0;
				dp_phase <= '0;
			end
		end
	end

	// Add-compare-select: predecessors of state n are {n[4:0], x}.
	generate
		for (genvar ns = 0; ns < NUM_STATES; ns++) begin : g_acs
			localparam logic [MEM_LEN-1:0] NS = MEM_LEN'(ns);
			localparam logic [MEM_LEN-1:0] P0 = {NS[MEM_LEN-2:0], 1'b0};
			localparam logic [MEM_LEN-1:0] P1 = {NS[MEM_LEN-2:0], 1'b1};
			logic [PMETRIC_W-1:0] cand0;
			logic [PMETRIC_W-1:0] cand1;
			always_comb begin
				cand0 = pm[P0] + branch_metric({NS, 1'b0}, pair);
				cand1 = pm[P1] + branch_metric({NS, 1'b1}, pair);
				if (metric_less(cand1, cand0)) begin
					next_pm[ns]   = cand1;
					next_surv[ns] = {surv[P1][TRUNC-2:0], NS[MEM_LEN-1]};
				end else begin
					next_pm[ns]   = cand0;
					next_surv[ns] = {surv[P0][TRUNC-2:0], NS[MEM_LEN-1]};
				end
			end
			always_ff @(posedge i_clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					pm[ns]   <= '0;
					surv[ns] <= '0;
				end else if (pair_valid) begin
					pm[ns]   <= next_pm[ns];
					surv[ns] <= next_surv[ns];
				end
			end
		end
	endgenerate

	// Linear search is slow but small; a tree would only help timing.
	always_comb begin
		best_state = '0;
		for (int s = 1; s < NUM_STATES; s++) begin
			if (metric_less(pm[s], pm[best_state]))
				best_state = MEM_LEN'(s);
		end
	end

	// Nothing leaves until the survivors hold a full truncation length.
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			fill        <= '0;
			o_dec_valid <= 1'b0;
			o_dec_bit   <= 1'b0;
		end else begin
			o_dec_valid <= 1'b0;
			if (pair_valid) begin
				if (fill != FILL_FULL)
					fill <= fill + 1'b1;
				else begin
					o_dec_valid <= 1'b1;
					o_dec_bit   <= surv[best_state][TRUNC-1];
				end
			end
		end
	end

endmodule : pcc_punctured_conv_codec

// ### core/pcc_pkg.sv
// Constants, types and puncturing helpers for the punctured convolutional codec.
package pcc_pkg;

	localparam int CONSTRAINT_LEN = 7;
	localparam int MEM_LEN        = CONSTRAINT_LEN - 1;
	localparam int NUM_STATES     = 1 << MEM_LEN;
	localparam int TRUNC_LEN      = 60;
	localparam int SOFT_W         = 6;
	localparam int PMETRIC_W      = 16;
	localparam int PHASE_W        = 3;

	// Encoder taps over {newest bit, six older bits}; newest bit is the MSB.
	localparam logic [6:0] GEN_FIRST_DEF  = 7'h79;
	localparam logic [6:0] GEN_SECOND_DEF = 7'h5B;

	typedef enum logic [2:0] {
		RATE_1_2 = 3'b000,
		RATE_2_3 = 3'b001,
		RATE_3_4 = 3'b010,
		RATE_5_6 = 3'b011,
		RATE_7_8 = 3'b100
	} pcc_rate_type;

	// Pattern masks: bit t-1 belongs to bit time t of the period.
	localparam logic [6:0] MASK1_1_2 = 7'h01;
	localparam logic [6:0] MASK2_1_2 = 7'h01;
	localparam logic [6:0] MASK1_2_3 = 7'h01;
	localparam logic [6:0] MASK2_2_3 = 7'h03;
	localparam logic [6:0] MASK1_3_4 = 7'h05;
	localparam logic [6:0] MASK2_3_4 = 7'h03;
	localparam logic [6:0] MASK1_5_6 = 7'h15;
	localparam logic [6:0] MASK2_5_6 = 7'h0B;
	localparam logic [6:0] MASK1_7_8 = 7'h51;
	localparam logic [6:0] MASK2_7_8 = 7'h2F;

	localparam logic [PHASE_W-1:0] PERIOD_1_2 = 3'h1;
	localparam logic [PHASE_W-1:0] PERIOD_2_3 = 3'h2;
	localparam logic [PHASE_W-1:0] PERIOD_3_4 = 3'h3;
	localparam logic [PHASE_W-1:0] PERIOD_5_6 = 3'h5;
	localparam logic [PHASE_W-1:0] PERIOD_7_8 = 3'h7;

	typedef struct packed {
		logic signed [SOFT_W-1:0] first_parity_symbol;
		logic signed [SOFT_W-1:0] second_parity_symbol;
	} pcc_soft_pair_type;

	typedef struct packed {
		logic keep_first;
		logic keep_second;
	} pcc_keep_type;

	function automatic logic [PHASE_W-1:0] punct_period(pcc_rate_type rate);
		case (rate)
			RATE_2_3: punct_period = PERIOD_2_3;
			RATE_3_4: punct_period = PERIOD_3_4;
			RATE_5_6: punct_period = PERIOD_5_6;
			RATE_7_8: punct_period = PERIOD_7_8;
			default:  punct_period = PERIOD_1_2;
		endcase
	endfunction : punct_period

	function automatic pcc_keep_type keep_bits(pcc_rate_type rate,
			logic [PHASE_W-1:0] phase);
		logic [6:0] m1;
		logic [6:0] m2;
		case (rate)
			RATE_2_3: begin m1 = MASK1_2_3; m2 = MASK2_2_3; end
			RATE_3_4: begin m1 = MASK1_3_4; m2 = MASK2_3_4; end
			RATE_5_6: begin m1 = MASK1_5_6; m2 = MASK2_5_6; end
			RATE_7_8: begin m1 = MASK1_7_8; m2 = MASK2_7_8; end
			default:  begin m1 = MASK1_1_2; m2 = MASK2_1_2; end
		endcase
		keep_bits.keep_first  = m1[phase];
		keep_bits.keep_second = m2[phase];
	endfunction : keep_bits

	function automatic logic [PHASE_W-1:0] next_phase(pcc_rate_type rate,
			logic [PHASE_W-1:0] phase);
		if (phase >= punct_period(rate) - 3'h1)
			next_phase = '0;
		else
			next_phase = phase + 3'h1;
	endfunction : next_phase

endpackage : pcc_pkg

// ### bench/pcc_props_properties.sv
// Concurrent checks on the codec stream ports.
`timescale 1ns/1ns
module pcc_props
	import pcc_pkg::*;
(
	// Clock, reset and rate.
	input wire logic         i_clk_sys,
	input wire logic         i_nrst,
	input wire pcc_rate_type i_rate,
	// Stream handshakes.
	input wire logic         i_enc_valid,
	input wire logic         o_enc_ready,
	input wire logic         o_enc_sym_valid,
	input wire logic         i_dec_valid,
	input wire logic         o_dec_valid
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_nrst);

	a_ready_release: assert property (
		$rose(i_nrst) |-> !o_enc_ready ##1 !o_enc_ready ##[1:3] o_enc_ready)
		else $error("ready timing after reset wrong");
	a_quiet_release: assert property (
		$rose(i_nrst) |-> (!o_enc_sym_valid && !o_dec_valid) [*2])
		else $error("output pulse right after reset");
	a_first_sym: assert property (
		(i_enc_valid && o_enc_ready) |-> ##2 o_enc_sym_valid)
		else $error("no symbol two cycles after a bit");
	a_pair_half: assert property (
		(i_enc_valid && o_enc_ready && i_rate == RATE_1_2) |=> !o_enc_ready
		##1 (o_enc_ready && o_enc_sym_valid) ##1 o_enc_sym_valid)
		else $error("unpunctured pair timing wrong");
	a_sym_cause: assert property (
		o_enc_sym_valid |-> $past(i_enc_valid && o_enc_ready, 2)
		|| $past(i_enc_valid && o_enc_ready, 3))
		else $error("symbol without a bit taken");
	a_enc_idle: assert property (
		!i_enc_valid [*4] |-> !o_enc_sym_valid)
		else $error("symbol while encoder idle");
	a_ready_back: assert property (
		$fell(o_enc_ready) |=> o_enc_ready)
		else $error("ready low for more than one cycle");
	a_dec_cause: assert property (
		o_dec_valid |-> $past(i_dec_valid, 2) || $past(i_dec_valid, 3)
		|| $past(i_dec_valid, 4))
		else $error("decoded bit without a symbol");
	a_dec_idle: assert property (
		!i_dec_valid [*5] |-> !o_dec_valid)
		else $error("decoded bit while decoder idle");
endmodule : pcc_props

// ### bench/pcc_chan_model.sv
// Modulator plus soft demodulator: maps channel symbols to soft values.
`timescale 1ns/1ns
module pcc_chan_model
	import pcc_pkg::*;
(
	// Modulator side.
	input  wire logic                i_clk_sys,
	input  wire logic                i_sym_valid,
	input  wire logic                i_sym,
	input  wire logic                i_corrupt,
	// Demodulator side.
	output logic                     o_valid,
	output logic signed [SOFT_W-1:0] o_sym
);
	int                       cnt = 0;
	logic signed [SOFT_W-1:0] amp;
	initial begin
		o_valid = 1'b0;
		o_sym = 6'h15;
	end
	// Errors are spaced far apart so one error event never overlaps the next.
	always @(negedge i_clk_sys) begin
		amp = 6'(8 + $urandom % 24);
		o_valid <= i_sym_valid;
		if (i_sym_valid) begin
			cnt++;
			o_sym <= (i_sym ^ (i_corrupt && cnt % 41 == 0)) ? amp : -amp;
		end else begin
			o_sym <= ~o_sym;
		end
	end
endmodule : pcc_chan_model

// ### bench/tb_top.sv
// Self-checking bench: codec looped through a soft channel model.
`timescale 1ns/1ns
module tb_top import pcc_pkg::*;;
	localparam int NB = 150;
	// Per rate: first mask, second mask, period; bit t-1 is bit time t.
	localparam logic [6:0] M1 [5] = '{7'h01, 7'h01, 7'h05, 7'h15, 7'h51};
	localparam logic [6:0] M2 [5] = '{7'h01, 7'h03, 7'h03, 7'h0B, 7'h2F};
	localparam int         PER [5] = '{1, 2, 3, 5, 7};
	logic                     clk = 1'b0, nrst = 1'b0, bad = 1'b0;
	logic                     ev = 1'b0, eb = 1'b0, es = 1'b0, ds = 1'b0;
	pcc_rate_type             rate = RATE_1_2;
	logic                     ready, sv, s, dv, ov, ob;
	logic signed [SOFT_W-1:0] dsym;
	logic [6:0]               sreg;
	int                       ph, n_dec, num_errors = 0, total_checks = 0;
	logic                     exp_sym[$], sent[$];

	pcc_punctured_conv_codec dut (
		.i_clk_sys      (clk),
		.i_nrst         (nrst),
		.i_rate         (rate),
		.i_enc_valid    (ev),
		.i_enc_bit      (eb),
		.i_enc_start    (es),
		.o_enc_ready    (ready),
		.o_enc_sym_valid(sv),
		.o_enc_sym      (s),
		.i_dec_valid    (dv),
		.i_dec_sym      (dsym),
		.i_dec_start    (ds),
		.o_dec_valid    (ov),
		.o_dec_bit      (ob)
	);
	pcc_chan_model u_chan (
		.i_clk_sys  (clk),
		.i_sym_valid(sv),
		.i_sym      (s),
		.i_corrupt  (bad),
		.o_valid    (dv),
		.o_sym      (dsym)
	);
	always #2 clk = ~clk;

	task automatic check(input logic [7:0] seen, exp, input string what);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %0t %s: saw %0h want %0h", $time, what, seen, exp);
		end
	endtask : check

	task automatic end_of_test();
		$display("TB: %0d checks, %0d errors", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : end_of_test

	// Reference parity of one generator over the seven newest bits.
	function automatic logic ref_parity(input logic [6:0] win, gen);
		ref_parity = ^(win & gen);
	endfunction : ref_parity

	// Expected symbols come from a reference shift register, newest bit MSB.
	task automatic send_bit(input logic b);
		int n;
		n = 0;
		sreg = {b, sreg[6:1]};
		if (M1[rate][ph])
			exp_sym.push_back(ref_parity(sreg, GEN_FIRST_DEF));
		if (M2[rate][ph])
			exp_sym.push_back(~ref_parity(sreg, GEN_SECOND_DEF));
		ph = (ph + 1) % PER[rate];
		sent.push_back(b);
		ev = 1'b1;
		eb = b;
		while (ready !== 1'b1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		if (ready !== 1'b1) begin
			check(8'h0, 8'h1, "ready timeout");
			end_of_test();
		end
		@(negedge clk);
	endtask : send_bit

	// Two zero bits shift the phase first, so the start pulse must realign.
	task automatic run_rate(input pcc_rate_type r, input logic noisy);
		nrst = 1'b0;
		ev = 1'b0;
		rate = r;
		bad = 1'b0;
		repeat (5) @(negedge clk);
		nrst = 1'b1;
		exp_sym.delete();
		sent.delete();
		sreg = '0;
		ph = 0;
		n_dec = 0;
		send_bit(1'b0);
		send_bit(1'b0);
		ev = 1'b0;
		ph = 0;
		repeat (6) @(negedge clk);
		es = 1'b1;
		ds = 1'b1;
		@(negedge clk);
		es = 1'b0;
		ds = 1'b0;
		for (int i = 0; i < NB; i++) begin
			// All states start level, so errors wait until the start is settled.
			bad = noisy && i >= 16;
			send_bit(i < 8 ? 1'b1 : 1'($urandom));
			if ($urandom % 4 == 0) begin
				ev = 1'b0;
				@(negedge clk);
			end
		end
		ev = 1'b0;
		repeat (12) @(negedge clk);
		check(8'(exp_sym.size()), 8'h0, "symbols missing");
		check(8'(n_dec), 8'(NB + 2 - TRUNC_LEN), "decoded count");
	endtask : run_rate

	always @(negedge clk) begin
		if (sv === 1'b1) begin
			check(s, exp_sym.pop_front(), "channel symbol");
		end
		if (ov === 1'b1) begin
			n_dec++;
			check(ob, sent.pop_front(), "decoded bit");
		end
	end

	initial begin
		void'($urandom(32'h8647a95b));
		for (int r = 0; r < 5; r++) begin
			run_rate(pcc_rate_type'(3'(r)), 1'b0);
		end
		run_rate(RATE_1_2, 1'b1);
		end_of_test();
	end
endmodule : tb_top

bind pcc_punctured_conv_codec pcc_props u_props (
	.i_clk_sys      (i_clk_sys),
	.i_nrst         (i_nrst),
	.i_rate         (i_rate),
	.i_enc_valid    (i_enc_valid),
	.o_enc_ready    (o_enc_ready),
	.o_enc_sym_valid(o_enc_sym_valid),
	.i_dec_valid    (i_dec_valid),
	.o_dec_valid    (o_dec_valid)
);
